// ### core/twbf_master.sv
// two-wire bus master: start, stop, address and data packet framing
`timescale 1ns/1ps
`default_nettype none
`include "twbf_regs.svh"
module twbf_master
  import twbf_pkg::*;
#(
  parameter int unsigned QUARTER_CYC = `TWBF_QUARTER_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic two_wire_power_reduction_bit,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire twbf_op_type cmd_op,
  input wire logic [`TWBF_BYTE_BITS-1:0] cmd_data,
  input wire logic cmd_rw,
  input wire logic cmd_last,
  output logic rsp_valid,
  output logic [`TWBF_BYTE_BITS-1:0] rsp_data,
  output logic rsp_ack,
  output logic rsp_err,
  output logic bus_busy,
  output logic bus_owned,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  localparam int TMR_W = $clog2(QUARTER_CYC + 1);

  logic rst_n;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic mon_busy;
  twbf_state_type state_q;
  twbf_state_type go_st;
  logic [1:0] ph_q;
  logic [TMR_W-1:0] tmr_q;
  logic [3:0] bit_q;
  logic [`TWBF_BYTE_BITS-1:0] sh_q;
  logic rd_q;
  logic last_q;
  logic ack_q;
  logic own_q;
  logic need_addr_q;
  logic addr_ok_q;
  logic dir_rd_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic scl_pull_d;
  logic sda_pull_d;
  logic bit_pull;
  logic legal;
  logic acc;
  logic running;
  logic wait_hi;
  logic tick;
  logic ph_end;
  logic addr_gc;
  logic addr_rsv;

  twbf_sync #(
    .W(1),
    .RST_VAL(1'h0)
  ) u_rst_sync (
    .clk(clk),
    .arst_n(nrst),
    .d(1'b1),
    .q(rst_n)
  );

  // pins are asynchronous to clk
  twbf_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(rst_n),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  twbf_busmon u_busmon (
    .clk(clk),
    .rst_n(rst_n),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .busy(mon_busy)
  );

  // no request is taken while the internal reset still holds
  assign cmd_ready = rst_n && (state_q == ST_IDLE) &&
                     !two_wire_power_reduction_bit;
  assign acc = cmd_valid && cmd_ready;
  assign rsp_valid = (state_q == ST_DONE);
  assign bus_busy = mon_busy;
  assign bus_owned = own_q;

  assign addr_gc = (cmd_data[`TWBF_ADDR_BITS-1:0] == `TWBF_GCALL_ADDR);
  assign addr_rsv = (cmd_data[6:3] == `TWBF_RSV_UPPER);

  // command legality; a refused command answers with an error
  always_comb begin
    legal = 1'b0;
    go_st = ST_DONE;
    unique case (cmd_op)
      TWBF_OP_START: begin
        legal = own_q || !mon_busy;
        go_st = ST_START;
      end
      TWBF_OP_ADDR: begin
        legal = need_addr_q && !(addr_gc && cmd_rw) && !addr_rsv;
        go_st = ST_BIT;
      end
      TWBF_OP_WRITE: begin
        legal = own_q && !need_addr_q && addr_ok_q && !dir_rd_q;
        go_st = ST_BIT;
      end
      TWBF_OP_READ: begin
        legal = own_q && !need_addr_q && addr_ok_q && dir_rd_q;
        go_st = ST_BIT;
      end
      TWBF_OP_STOP: begin
        legal = own_q && !need_addr_q;
        go_st = ST_STOP;
      end
      default: begin
        legal = 1'b0;
        go_st = ST_DONE;
      end
    endcase
    if (!legal) begin
      go_st = ST_DONE;
    end
  end

  // quarter-period timer; cleared while a released clock is still low
  assign running = (state_q == ST_START) || (state_q == ST_BIT) ||
                   (state_q == ST_STOP);
  assign wait_hi = !scl_s &&
                   (((state_q == ST_START) && (ph_q == 2'h1)) ||
                    ((state_q == ST_BIT) && (ph_q == 2'h2)) ||
                    ((state_q == ST_STOP) && (ph_q == 2'h2)));
  assign tick = running && !wait_hi &&
                (tmr_q == TMR_W'(QUARTER_CYC - 1));
  assign ph_end = tick && (ph_q == `TWBF_PH_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (!running || wait_hi || tick) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + TMR_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      ph_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          ph_q <= 2'h0;
          if (acc) begin
            state_q <= go_st;
          end
        end
        ST_START, ST_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
          end
          if (ph_end) begin
            state_q <= ST_DONE;
          end
        end
        ST_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
          end
          if (ph_end && (bit_q == `TWBF_ACK_IDX)) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // shifter, bit counter and acknowledge capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (acc && legal) begin
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      last_q <= cmd_last;
      rd_q <= (cmd_op == TWBF_OP_READ);
      if (cmd_op == TWBF_OP_ADDR) begin
        sh_q <= {cmd_data[`TWBF_ADDR_BITS-1:0], cmd_rw};
      end else if (cmd_op == TWBF_OP_WRITE) begin
        sh_q <= cmd_data;
      end else begin
        sh_q <= 8'h00;
      end
    end else if ((state_q == ST_BIT) && tick) begin
      if (ph_q == 2'h2) begin
        // sample a quarter after the clock is seen high
        if (bit_q == `TWBF_ACK_IDX) begin
          ack_q <= !sda_s;
        end else if (rd_q) begin
          sh_q <= {sh_q[6:0], sda_s};
        end
      end else if ((ph_q == `TWBF_PH_LAST) && (bit_q != `TWBF_ACK_IDX)) begin
        bit_q <= bit_q + 4'h1;
        if (!rd_q) begin
          sh_q <= {sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // bus ownership and transfer progress
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_q <= 1'b0;
      need_addr_q <= 1'b0;
      addr_ok_q <= 1'b0;
      dir_rd_q <= 1'b0;
    end else if (acc && legal && (cmd_op == TWBF_OP_ADDR)) begin
      dir_rd_q <= cmd_rw;
    end else if (ph_end && (state_q == ST_START)) begin
      own_q <= 1'b1;
      need_addr_q <= 1'b1;
      addr_ok_q <= 1'b0;
    end else if (ph_end && (state_q == ST_STOP)) begin
      own_q <= 1'b0;
      need_addr_q <= 1'b0;
      addr_ok_q <= 1'b0;
    end else if (ph_end && (state_q == ST_BIT) &&
                 (bit_q == `TWBF_ACK_IDX)) begin
      need_addr_q <= 1'b0;
      // a refusal or our own final nack leaves only stop or restart
      addr_ok_q <= rd_q ? !last_q : ack_q;
    end
  end

  // answer latched when the operation ends or is refused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
      rsp_err <= 1'b0;
    end else if (acc && !legal) begin
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
      rsp_err <= 1'b1;
    end else if (ph_end) begin
      rsp_err <= 1'b0;
      rsp_data <= rd_q && (state_q == ST_BIT) ? sh_q : 8'h00;
      rsp_ack <= (state_q == ST_BIT) && (rd_q ? !last_q : ack_q);
    end
  end

  // line drive per state and phase; data moves in clock-low phases except at the start and stop edges, made with clock high
  assign bit_pull = (bit_q == `TWBF_ACK_IDX) ? (rd_q && !last_q) :
                    (!rd_q && !sh_q[7]);
  always_comb begin
    scl_pull_d = scl_oe_q;
    sda_pull_d = sda_oe_q;
    unique case (state_q)
      ST_IDLE: begin
        scl_pull_d = own_q;
        // data let go a cycle after the clock is pulled, never with it
        sda_pull_d = sda_oe_q && !scl_oe_q;
      end
      ST_START: begin
        scl_pull_d = (ph_q == 2'h0) ? scl_oe_q : (ph_q == `TWBF_PH_LAST);
        sda_pull_d = ph_q[1];
      end
      ST_BIT: begin
        scl_pull_d = !ph_q[1];
        sda_pull_d = (ph_q == 2'h0) ? sda_oe_q : bit_pull;
      end
      ST_STOP: begin
        scl_pull_d = !ph_q[1];
        sda_pull_d = (ph_q == 2'h0) ? sda_oe_q : (ph_q != `TWBF_PH_LAST);
      end
      ST_DONE: begin
        scl_pull_d = scl_oe_q;
        sda_pull_d = sda_oe_q;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_pull_d;
      sda_oe_q <= sda_pull_d;
    end
  end

  // open drain: drive value is always low, only the enable moves
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;

  a_data_stable_hi: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_BIT) && $changed(sda_oe_q)
      |-> scl_oe_q && $past(scl_oe_q)
  ) else $error("data changed while clock high");

  a_start_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_START) && $rose(sda_oe_q) |-> !scl_oe_q && scl_s
  ) else $error("start not made with clock high");

  a_stop_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_STOP) && $fell(sda_oe_q) |-> !scl_oe_q && scl_s
  ) else $error("stop not made with clock high");

  a_start_when_busy: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc && (cmd_op == TWBF_OP_START) && !own_q && mon_busy
      |=> rsp_valid && rsp_err && (state_q == ST_DONE)
  ) else $error("start taken on a busy bus");

  a_own_until_stop: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(own_q) |-> $past(state_q) == ST_STOP
  ) else $error("bus released without stop");

  a_packet_length: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_BIT) ##1 (state_q == ST_DONE)
      |-> $past(bit_q) == `TWBF_ACK_IDX
  ) else $error("packet not nine bits");

  a_msb_first: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_BIT) && !rd_q && (bit_q < `TWBF_ACK_IDX) && ph_q[1]
      |-> sda_oe_q == !sh_q[7]
  ) else $error("wrong bit on data line");

  a_ack_released: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_BIT) && !rd_q && (bit_q == `TWBF_ACK_IDX) && ph_q[1]
      |-> !sda_oe_q
  ) else $error("master drove the slave acknowledge");

  a_read_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_BIT) && rd_q && (bit_q == `TWBF_ACK_IDX) && ph_q[1]
      |-> sda_oe_q == !last_q
  ) else $error("wrong acknowledge after read byte");

  a_gcall_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc && (cmd_op == TWBF_OP_ADDR) && addr_gc && cmd_rw
      |=> rsp_err ##1 (state_q == ST_IDLE) && !sda_oe_q
  ) else $error("general call read not refused");

  a_rsv_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc && (cmd_op == TWBF_OP_ADDR) && addr_rsv |=> rsp_valid && rsp_err
  ) else $error("reserved address not refused");

  a_nack_refuse: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc && ((cmd_op == TWBF_OP_WRITE) || (cmd_op == TWBF_OP_READ)) &&
      !addr_ok_q |=> rsp_err
  ) else $error("data packet after refusal");

  a_no_empty: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc && (cmd_op == TWBF_OP_STOP) && need_addr_q
      |=> rsp_err && (state_q == ST_DONE)
  ) else $error("empty transfer not refused");

  a_stretch_wait: assert property (
    @(posedge clk) disable iff (!rst_n)
    wait_hi |=> (tmr_q == TMR_W'(0)) && $stable(ph_q)
  ) else $error("clock high counted while held low");
endmodule
`default_nettype wire

// ### inc/twbf_regs.svh
// timing counts and field constants of the two-wire bus master
`ifndef TWBF_REGS_SVH
`define TWBF_REGS_SVH
`define TWBF_CLK_NS 10
`define TWBF_T_QUARTER_NS 2500
`define TWBF_QUARTER_CYC ((`TWBF_T_QUARTER_NS+`TWBF_CLK_NS-1)/`TWBF_CLK_NS)
`define TWBF_BYTE_BITS 8
`define TWBF_ADDR_BITS 7
`define TWBF_ACK_IDX 4'h8
`define TWBF_GCALL_ADDR 7'h00
`define TWBF_RSV_UPPER 4'hF
`define TWBF_PH_LAST 2'h3
`endif

// ### inc/twbf_pkg.sv
// types of the two-wire bus master
package twbf_pkg;
  typedef enum logic [2:0] {
    TWBF_OP_START,
    TWBF_OP_ADDR,
    TWBF_OP_WRITE,
    TWBF_OP_READ,
    TWBF_OP_STOP
  } twbf_op_type;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP,
    ST_DONE
  } twbf_state_type;
endpackage

// ### core/twbf_sync.sv
// two-flop synchroniser with a constant reset value
`timescale 1ns/1ps
`default_nettype none
module twbf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### core/twbf_busmon.sv
// start and stop detection on the synchronised lines, bus busy flag
`timescale 1ns/1ps
`default_nettype none
module twbf_busmon (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic busy
);
  logic scl_p_q;
  logic sda_p_q;
  logic start_seen;
  logic stop_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  // data edge while the clock stays high
  assign start_seen = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_seen = scl_s && scl_p_q && !sda_p_q && sda_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (start_seen) begin
      busy <= 1'b1;
    end else if (stop_seen) begin
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/twbf_slave_model.sv
// behavioural slave node sitting on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module twbf_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic gc_en,
  input wire logic busy,
  input wire logic [15:0] stretch_ns,
  input wire logic [7:0] rd_byte,
  output logic [7:0] rx_byte,
  output logic sda_pull,
  output logic scl_pull
);
  int cnt = 0;
  logic first = 1'h1;
  logic sel = 1'h0;
  logic rd = 1'h0;
  logic mack = 1'h0;
  logic [7:0] sr = 8'h00;
  initial begin
    sda_pull = 1'h0;
    scl_pull = 1'h0;
    rx_byte = 8'h00;
  end
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
      first = 1'h1;
      sel = 1'h0;
    end
  end
  always @(posedge sda)
    if (scl)
      sel = 1'h0;
  always @(posedge scl) begin
    if (cnt < 8)
      sr = {sr[6:0], sda};
    else
      mack = !sda;
    cnt = cnt + 1;
  end
  // lines only ever pulled low, changed only while the clock is low
  always @(negedge scl) begin
    sda_pull = 1'h0;
    if (cnt == 8 && first) begin
      sel = !busy && (sr[7:1] == OWN_ADDR ||
            (sr[7:1] == 7'h00 && gc_en && !sr[0]));
      rd = sr[0];
      sda_pull = sel;
    end else if (cnt == 8 && sel && !rd) begin
      rx_byte = sr;
      sda_pull = 1'h1;
    end else if (cnt == 9) begin
      cnt = 0;
      if (!first && rd && !mack)
        sel = 1'h0;
      first = 1'h0;
      sda_pull = sel && rd && !rd_byte[7];
    end else if (cnt < 8 && sel && rd && !first)
      sda_pull = !rd_byte[7 - cnt];
  end
  always @(negedge scl) begin
    if (stretch_ns > 16'h0000) begin
      scl_pull = 1'h1;
      #(stretch_ns);
      scl_pull = 1'h0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import twbf_pkg::*;
;
  localparam int Q = 4;
  typedef struct {
    twbf_op_type op;
    logic [7:0] d;
    logic [1:0] ctl;
    logic [2:0] ex;
    logic [7:0] dat;
  } twbf_row_type;
  // ctl is {rw, last}; ex is {err, ack, busy}
  twbf_row_type rows [25] = '{
    '{TWBF_OP_READ, 8'h00, 2'h0, 3'h4, 8'h00},
    '{TWBF_OP_START, 8'h00, 2'h0, 3'h1, 8'h00},
    '{TWBF_OP_STOP, 8'h00, 2'h0, 3'h5, 8'h00},
    '{TWBF_OP_ADDR, 8'h2A, 2'h0, 3'h3, 8'h00},
    '{TWBF_OP_WRITE, 8'h3C, 2'h0, 3'h3, 8'h00},
    '{TWBF_OP_WRITE, 8'hC3, 2'h0, 3'h3, 8'h00},
    '{TWBF_OP_START, 8'h00, 2'h0, 3'h1, 8'h00},
    '{TWBF_OP_ADDR, 8'h2A, 2'h2, 3'h3, 8'h00},
    '{TWBF_OP_WRITE, 8'h11, 2'h0, 3'h5, 8'h00},
    '{TWBF_OP_READ, 8'h00, 2'h0, 3'h3, 8'hA5},
    '{TWBF_OP_READ, 8'h00, 2'h1, 3'h1, 8'hA5},
    '{TWBF_OP_READ, 8'h00, 2'h0, 3'h5, 8'h00},
    '{TWBF_OP_STOP, 8'h00, 2'h0, 3'h0, 8'h00},
    '{TWBF_OP_START, 8'h00, 2'h0, 3'h1, 8'h00},
    '{TWBF_OP_ADDR, 8'h55, 2'h0, 3'h1, 8'h00},
    '{TWBF_OP_WRITE, 8'h22, 2'h0, 3'h5, 8'h00},
    '{TWBF_OP_START, 8'h00, 2'h0, 3'h1, 8'h00},
    '{TWBF_OP_ADDR, 8'h00, 2'h2, 3'h5, 8'h00},
    '{TWBF_OP_START, 8'h00, 2'h0, 3'h1, 8'h00},
    '{TWBF_OP_ADDR, 8'h7B, 2'h0, 3'h5, 8'h00},
    '{TWBF_OP_START, 8'h00, 2'h0, 3'h1, 8'h00},
    '{TWBF_OP_ADDR, 8'h00, 2'h0, 3'h3, 8'h00},
    '{TWBF_OP_WRITE, 8'h5A, 2'h0, 3'h3, 8'h00},
    '{TWBF_OP_STOP, 8'h00, 2'h0, 3'h0, 8'h00},
    '{twbf_op_type'(3'h5), 8'h00, 2'h0, 3'h4, 8'h00}
  };
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic pwr_off = 1'h0;
  logic cmd_valid = 1'h0;
  twbf_op_type cmd_op = TWBF_OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_rw = 1'h0;
  logic cmd_last = 1'h0;
  logic cmd_ready, rsp_valid, rsp_ack, rsp_err, bus_busy, bus_owned;
  logic [7:0] rsp_data, rx_byte;
  logic scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda;
  logic s_busy = 1'h0;
  logic x_sda = 1'h0;
  logic [15:0] stretch = 16'h0000;
  wire logic scl;
  wire logic sda;
  int n_fail = 0;
  int checked = 0;
  int n_hi_edge = 0;
  time t_hi = 0;
  time hi_min = 1000000;
  always #5 clk = ~clk;
  // pulled-up wired-AND of both parties
  assign scl = ~scl_oe & ~s_scl;
  // x_sda stands in for another master taking the bus
  assign sda = ~sda_oe & ~s_sda & ~x_sda;
  twbf_master #(.QUARTER_CYC(Q)) u_dut (.clk(clk), .nrst(nrst),
    .two_wire_power_reduction_bit(pwr_off), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_rw(cmd_rw), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_err(rsp_err),
    .bus_busy(bus_busy), .bus_owned(bus_owned), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe));
  twbf_slave_model #(.OWN_ADDR(7'h2A)) u_slave (.scl(scl), .sda(sda),
    .gc_en(1'h1), .busy(s_busy), .stretch_ns(stretch),
    .rd_byte(8'hA5), .rx_byte(rx_byte), .sda_pull(s_sda),
    .scl_pull(s_scl));
  // data edges while the clock is high are only start or stop
  always @(sda)
    if (scl === 1'h1 && nrst)
      n_hi_edge++;
  always @(posedge scl) t_hi = $time;
  always @(negedge scl)
    if ($time - t_hi < hi_min)
      hi_min = $time - t_hi;
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic fail(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp)
      fail(m);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string m);
    checked++;
    if (got !== exp)
      fail(m);
  endtask
  task automatic do_cmd(input twbf_op_type op, input logic [7:0] d,
                        input logic [1:0] ctl);
    int n;
    n = 0;
    while (cmd_ready !== 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    cmd_op = op;
    cmd_data = d;
    {cmd_rw, cmd_last} = ctl;
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000)
      fail("no answer");
  endtask
  initial begin
    #1000000;
    fail("watchdog expired");
    test_done;
  end
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'h1;
    foreach (rows[i]) begin
      do_cmd(rows[i].op, rows[i].d, rows[i].ctl);
      chk_bit(rsp_err, rows[i].ex[2], "refusal flag");
      if (!rows[i].ex[2] &&
          rows[i].op inside {TWBF_OP_ADDR, TWBF_OP_WRITE, TWBF_OP_READ})
        chk_bit(rsp_ack, rows[i].ex[1], "ack");
      chk_byte(rsp_data, rows[i].dat, "read byte");
      repeat (4) @(negedge clk);
      chk_bit(bus_busy, rows[i].ex[0], "bus busy");
    end
    chk_byte(rx_byte, 8'h5A, "general call data");
    chk_byte(8'(n_hi_edge), 8'h08, "edges with clock high");
    s_busy = 1'h1;
    do_cmd(TWBF_OP_START, 8'h00, 2'h0);
    do_cmd(TWBF_OP_ADDR, 8'h2A, 2'h0);
    chk_bit(rsp_ack, 1'h0, "busy slave acked");
    do_cmd(TWBF_OP_STOP, 8'h00, 2'h0);
    chk_bit(rsp_err, 1'h0, "stop after nack");
    s_busy = 1'h0;
    stretch = 16'd300;
    hi_min = 1000000;
    do_cmd(TWBF_OP_START, 8'h00, 2'h0);
    do_cmd(TWBF_OP_ADDR, 8'h2A, 2'h2);
    do_cmd(TWBF_OP_READ, 8'h00, 2'h1);
    chk_byte(rsp_data, 8'hA5, "stretched read");
    do_cmd(TWBF_OP_STOP, 8'h00, 2'h0);
    stretch = 16'h0000;
    chk_bit(hi_min >= Q * 10, 1'h1, "short clock high");
    x_sda = 1'h1;
    repeat (6) @(negedge clk);
    chk_bit(bus_busy, 1'h1, "foreign start missed");
    do_cmd(TWBF_OP_START, 8'h00, 2'h0);
    chk_bit(rsp_err, 1'h1, "start taken on busy bus");
    x_sda = 1'h0;
    repeat (6) @(negedge clk);
    chk_bit(bus_busy, 1'h0, "foreign stop missed");
    pwr_off = 1'h1;
    repeat (3) @(negedge clk);
    chk_bit(cmd_ready, 1'h0, "ready while powered off");
    pwr_off = 1'h0;
    @(negedge clk);
    chk_bit(cmd_ready, 1'h1, "ready after power on");
    chk_bit(scl_o | sda_o, 1'h0, "line driven high");
    do_cmd(TWBF_OP_START, 8'h00, 2'h0);
    do_cmd(TWBF_OP_ADDR, 8'h2A, 2'h0);
    chk_bit(bus_owned, 1'h1, "bus not held after start");
    nrst = 1'h0;
    #1;
    chk_bit(scl_oe | sda_oe, 1'h0, "lines held in reset");
    chk_bit(bus_owned, 1'h0, "owned in reset");
    test_done;
  end
endmodule
`default_nettype wire
